// ==== hdl/ssc_sequencer.sv ====
// Slot sequencer: configuration registers, slot decode and timing core
module ssc_sequencer
    import ssc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire ssc_req_type reg_req,
    output logic [7:0] reg_rdata,
    input wire logic en_pin,
    input wire logic [11:0] rail_monitor_good,
    input wire logic conv_done,
    output logic [11:0] en_out,
    output logic reset_out_n,
    output logic [3:0] tracking_sense_pulldown,
    output logic [1:0] slew_sel,
    output logic fault_active,
    output logic power_on
);

    typedef enum logic [3:0] {
        ST_IDLE, ST_UP_CHECK, ST_UP_DELAY, ST_ON,
        ST_DN_STEP, ST_DN_CHECK, ST_DN_WAIT, ST_FAULT, ST_RETRY, ST_LATCHED
    } ssc_state_type;

    // Register file
    logic [7:0] regs_reg [SSC_REG_FIRST:SSC_REG_LAST];
    logic [7:0] regs_next [SSC_REG_FIRST:SSC_REG_LAST];
    logic [7:0] rdata_reg, rdata_next;

    function automatic logic [7:0] wr_mask(input logic [7:0] a);
        // 54h top bits unused, 5Ch/5Dh absent
        if (a == SSC_DLY_REV_OFS) return 8'h1F;
        if (a == 8'h5C || a == 8'h5D) return 8'h00;
        return 8'hFF;
    endfunction : wr_mask

    always_comb begin
        regs_next = regs_reg;
        rdata_next = rdata_reg;
        if (reg_req.wr && reg_req.addr >= SSC_REG_FIRST &&
            reg_req.addr <= SSC_REG_LAST) begin
            regs_next[reg_req.addr] = reg_req.wdata & wr_mask(reg_req.addr);
        end
        if (reg_req.rd) begin
            if (reg_req.addr >= SSC_REG_FIRST && reg_req.addr <= SSC_REG_LAST)
            begin
                rdata_next = regs_reg[reg_req.addr];
            end else begin
                rdata_next = 8'h00;
            end
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = SSC_REG_FIRST; i <= SSC_REG_LAST; i++) begin
                regs_reg[i] <= SSC_REG_RST;
            end
            rdata_reg <= SSC_REG_RST;
        end else begin
            regs_reg <= regs_next;
            rdata_reg <= rdata_next;
        end
    end

    assign reg_rdata = rdata_reg;

    logic [7:0] cfg_to, cfg_rt, cfg_rev;
    assign cfg_to = regs_reg[SSC_TIMEOUT_PD_OFS];
    assign cfg_rt = regs_reg[SSC_RETRY_OFS];
    assign cfg_rev = regs_reg[SSC_DLY_REV_OFS];
    assign tracking_sense_pulldown = cfg_to[SSC_PULLDOWN_LSB +: 4];
    assign slew_sel = cfg_rt[SSC_SLEW_LSB +: 2];

    // Slot delay code per slot, split fields joined here
    function automatic logic [2:0] slot_code(input logic [3:0] s);
        logic [7:0] a, b, c, d, e;
        a = regs_reg[SSC_DLY_A_OFS];
        b = regs_reg[SSC_DLY_B_OFS];
        c = regs_reg[SSC_DLY_C_OFS];
        d = regs_reg[SSC_DLY_D_OFS];
        e = regs_reg[SSC_DLY_REV_OFS];
        unique case (s)
            4'h0: return a[2:0];
            4'h1: return a[5:3];
            4'h2: return {b[0], a[7:6]};
            4'h3: return b[3:1];
            4'h4: return b[6:4];
            4'h5: return {c[1:0], b[7]};
            4'h6: return c[4:2];
            4'h7: return c[7:5];
            4'h8: return d[2:0];
            4'h9: return d[5:3];
            4'hA: return {e[0], d[7:6]};
            4'hB: return e[3:1];
            default: return 3'h0; // Slot 12 always uses delay code 0, not a register field
        endcase
    endfunction : slot_code

    function automatic logic [SSC_TIMER_W-1:0] dly_ticks(input logic [2:0] c);
        return SSC_TIMER_W'(SSC_DLY_US[c] / SSC_TICK_US);
    endfunction : dly_ticks

    function automatic logic [SSC_TIMER_W-1:0] to_ticks(input logic [1:0] c);
        return SSC_TIMER_W'(SSC_FT_US[c] / SSC_TICK_US);
    endfunction : to_ticks

    // Slot decode into per-slot masks
    logic [11:0] out_mask [0:11];
    logic [11:0] mon_mask [0:12];
    logic [11:0] mon_assigned;
    logic [3:0] fld;

    always_comb begin
        for (int s = 0; s < 12; s++) out_mask[s] = 12'h000;
        for (int s = 0; s < 13; s++) mon_mask[s] = 12'h000;
        mon_assigned = 12'h000;
        fld = 4'h0;
        for (int i = 0; i < 12; i++) begin
            fld = regs_reg[SSC_MON_SLOT_OFS + 8'(i / 2)][(i % 2) * 4 +: 4];
            if (fld != 4'h0 && fld <= SSC_SLOT_CODE_MAX) begin
                mon_mask[fld][i] = 1'b1;
                mon_assigned[i] = 1'b1;
            end
            fld = regs_reg[SSC_OUT_SLOT_OFS + 8'(i / 2)][(i % 2) * 4 +: 4];
            if (fld != 4'h0 && fld <= SSC_SLOT_CODE_MAX) begin
                out_mask[fld - 4'h1][i] = 1'b1;
            end
        end
    end

    // Enable pin synchroniser; level changes once stages two and three agree
    logic en_s1_reg, en_s2_reg, en_s3_reg, en_lvl_reg;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_s1_reg <= 1'b0;
            en_s2_reg <= 1'b0;
            en_s3_reg <= 1'b0;
            en_lvl_reg <= 1'b0;
        end else begin
            en_s1_reg <= en_pin;
            en_s2_reg <= en_s1_reg;
            en_s3_reg <= en_s2_reg;
            if (en_s2_reg == en_s3_reg) en_lvl_reg <= en_s3_reg;
        end
    end

    logic stop_req;
    assign stop_req = !en_lvl_reg ||
                      regs_reg[SSC_SW_ENABLE_OFS][SSC_SW_DIS_BIT];

    // 20 us tick divider
    logic [8:0] pre_reg, pre_next;
    logic tick;
    assign tick = (pre_reg == 9'(SSC_TICK_CYCLES - 1));
    assign pre_next = tick ? 9'h000 : pre_reg + 9'h001;

    // Sequencer state
    ssc_state_type state_reg, state_next;
    logic [3:0] slot_reg, slot_next;
    logic [SSC_TIMER_W-1:0] timer_reg, timer_next;
    logic [11:0] en_out_reg, en_out_next;
    logic [4:0] glitch_reg, glitch_next;
    logic slot_good, slot_fallen, timer_done, glitch_fault;

    assign slot_good = (rail_monitor_good & mon_mask[slot_reg]) ==
                       mon_mask[slot_reg];
    assign slot_fallen = (rail_monitor_good & mon_mask[slot_reg + 4'h1]) ==
                         12'h000;
    assign timer_done = (timer_reg == '0);
    assign glitch_fault = (glitch_reg ==
        5'(SSC_DEGLITCH_CNT[cfg_rt[SSC_DEGLITCH_LSB +: 2]]));

    always_comb begin
        state_next = state_reg;
        slot_next = slot_reg;
        en_out_next = en_out_reg;
        glitch_next = glitch_reg;
        timer_next = (tick && !timer_done) ? timer_reg - 1'b1 : timer_reg;
        // Failing rail must persist over consecutive conversions
        if (state_reg != ST_ON) begin
            glitch_next = 5'h00;
        end else if (conv_done && !glitch_fault) begin
            if ((mon_assigned & ~rail_monitor_good) != 12'h000) begin
                glitch_next = glitch_reg + 5'h01;
            end else begin
                glitch_next = 5'h00;
            end
        end
        unique case (state_reg)
            ST_IDLE: begin
                if (!stop_req) begin
                    slot_next = 4'h0;
                    en_out_next = out_mask[0];
                    timer_next = dly_ticks(slot_code(4'h0));
                    state_next = ST_UP_DELAY;
                end
            end
            ST_UP_CHECK, ST_UP_DELAY, ST_ON: begin
                if (stop_req) begin
                    if (cfg_rev[SSC_REVERSE_BIT]) begin
                        slot_next = SSC_LAST_OUT_SLOT;
                        state_next = ST_DN_STEP;
                    end else begin
                        en_out_next = 12'h000;
                        state_next = ST_IDLE;
                    end
                end else if (state_reg == ST_UP_CHECK) begin
                    if (slot_good) begin
                        timer_next = dly_ticks(slot_code(slot_reg));
                        state_next = ST_UP_DELAY;
                    end else if (timer_done) begin
                        state_next = ST_FAULT;
                    end
                end else if (state_reg == ST_UP_DELAY) begin
                    if (timer_done) begin
                        if (slot_reg == SSC_LAST_MON_SLOT) begin
                            state_next = ST_ON;
                        end else begin
                            if (slot_reg != 4'h0) begin
                                en_out_next = en_out_reg | out_mask[slot_reg];
                            end
                            slot_next = slot_reg + 4'h1;
                            timer_next = to_ticks(cfg_to[SSC_PU_TO_LSB +: 2]);
                            state_next = ST_UP_CHECK;
                        end
                    end
                end else if (glitch_fault) begin
                    state_next = ST_FAULT;
                end
            end
            ST_DN_STEP: begin
                en_out_next = en_out_reg & ~out_mask[slot_reg];
                timer_next = to_ticks(cfg_to[SSC_PD_TO_LSB +: 2]);
                state_next = ST_DN_CHECK;
            end
            ST_DN_CHECK: begin
                // Rails fed by this slot are watched one slot later
                if (slot_fallen) begin
                    timer_next = dly_ticks(slot_code(slot_reg));
                    state_next = ST_DN_WAIT;
                end else if (timer_done) begin
                    state_next = ST_FAULT;
                end
            end
            ST_DN_WAIT: begin
                if (timer_done) begin
                    if (slot_reg == 4'h0) begin
                        state_next = ST_IDLE;
                    end else begin
                        slot_next = slot_reg - 4'h1;
                        state_next = ST_DN_STEP;
                    end
                end
            end
            ST_FAULT: begin
                en_out_next = 12'h000;
                if (cfg_rt[SSC_LATCH_BIT]) begin
                    state_next = ST_LATCHED;
                end else begin
                    timer_next = dly_ticks(cfg_rt[SSC_RETRY_LSB +: 3]);
                    state_next = ST_RETRY;
                end
            end
            ST_RETRY: begin
                if (timer_done) state_next = ST_IDLE;
            end
            ST_LATCHED: begin
                // Held off until the system asks for power-down
                if (stop_req) state_next = ST_IDLE;
            end
            default: state_next = ST_IDLE;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_reg <= ST_IDLE;
            slot_reg <= 4'h0;
            timer_reg <= '0;
            en_out_reg <= 12'h000;
            glitch_reg <= 5'h00;
            pre_reg <= 9'h000;
        end else begin
            state_reg <= state_next;
            slot_reg <= slot_next;
            timer_reg <= timer_next;
            en_out_reg <= en_out_next;
            glitch_reg <= glitch_next;
            pre_reg <= pre_next;
        end
    end

    assign en_out = en_out_reg;
    assign power_on = (state_reg == ST_ON);
    assign reset_out_n = (state_reg == ST_ON);
    assign fault_active = (state_reg == ST_FAULT) || (state_reg == ST_RETRY)
                          || (state_reg == ST_LATCHED);

    chk_reset_on_only: assert property (@(posedge clk) disable iff (rst)
        (state_reg == ST_ON && stop_req) |=> !reset_out_n)
        else $error("reset output not asserted at power-down start");
    chk_pulldown_write: assert property (@(posedge clk) disable iff (rst)
        (reg_req.wr && reg_req.addr == SSC_TIMEOUT_PD_OFS) |=>
        tracking_sense_pulldown == $past(reg_req.wdata[7:4]))
        else $error("pulldown enables do not follow register");
    chk_slot0_first: assert property (@(posedge clk) disable iff (rst)
        (state_reg == ST_IDLE && !stop_req) |=>
        (en_out == $past(out_mask[0]) && state_reg == ST_UP_DELAY))
        else $error("slot 0 outputs not asserted first");
    chk_pu_timeout: assert property (@(posedge clk) disable iff (rst)
        (state_reg == ST_UP_CHECK && timer_done && !slot_good && !stop_req)
        |=> state_reg == ST_FAULT)
        else $error("power-up timeout did not raise fault");
    chk_fault_latch: assert property (@(posedge clk) disable iff (rst)
        (state_reg == ST_FAULT && cfg_rt[SSC_LATCH_BIT]) |=>
        (state_reg == ST_LATCHED && en_out == 12'h000)[*2])
        else $error("latch-off did not hold outputs low");
    chk_retry_load: assert property (@(posedge clk) disable iff (rst)
        (state_reg == ST_FAULT && !cfg_rt[SSC_LATCH_BIT]) |=>
        (state_reg == ST_RETRY && timer_reg ==
         dly_ticks($past(cfg_rt[2:0]))))
        else $error("autoretry wait not loaded");
    chk_reverse_start: assert property (@(posedge clk) disable iff (rst)
        (state_reg == ST_ON && stop_req && cfg_rev[SSC_REVERSE_BIT]) |=>
        (state_reg == ST_DN_STEP && slot_reg == SSC_LAST_OUT_SLOT))
        else $error("reverse power-down not from slot 11");
    chk_simul_off: assert property (@(posedge clk) disable iff (rst)
        (state_reg == ST_ON && stop_req && !cfg_rev[SSC_REVERSE_BIT]) |=>
        (en_out == 12'h000 && state_reg == ST_IDLE))
        else $error("simultaneous power-down left outputs on");
    chk_pu_timer_load: assert property (@(posedge clk) disable iff (rst)
        (state_reg == ST_UP_DELAY && timer_done && !stop_req &&
         slot_reg != SSC_LAST_MON_SLOT) |=>
        timer_reg == to_ticks($past(cfg_to[1:0])))
        else $error("power-up timeout not loaded");
    chk_deglitch_fault: assert property (@(posedge clk) disable iff (rst)
        (state_reg == ST_ON && !stop_req && glitch_fault) |=>
        state_reg == ST_FAULT ##1 en_out == 12'h000)
        else $error("persistent rail failure not acted on");

endmodule : ssc_sequencer

// ==== hdl/ssc_pkg.sv ====
// Constants and carrier types for the slot sequencer configuration core
package ssc_pkg;

    // Register map: byte offsets on the configuration port
    localparam logic [7:0] SSC_SW_ENABLE_OFS = 8'h4D;
    localparam logic [7:0] SSC_TIMEOUT_PD_OFS = 8'h4E;
    localparam logic [7:0] SSC_RETRY_OFS = 8'h4F;
    localparam logic [7:0] SSC_DLY_A_OFS = 8'h50;
    localparam logic [7:0] SSC_DLY_B_OFS = 8'h51;
    localparam logic [7:0] SSC_DLY_C_OFS = 8'h52;
    localparam logic [7:0] SSC_DLY_D_OFS = 8'h53;
    localparam logic [7:0] SSC_DLY_REV_OFS = 8'h54;
    localparam logic [7:0] SSC_MON_SLOT_OFS = 8'h56;
    localparam logic [7:0] SSC_OUT_SLOT_OFS = 8'h5E;
    localparam logic [7:0] SSC_REG_FIRST = 8'h4D;
    localparam logic [7:0] SSC_REG_LAST = 8'h63;
    localparam logic [7:0] SSC_REG_RST = 8'h00;

    // Field positions
    localparam int SSC_PU_TO_LSB = 0;
    localparam int SSC_PD_TO_LSB = 2;
    localparam int SSC_PULLDOWN_LSB = 4;
    localparam int SSC_RETRY_LSB = 0;
    localparam int SSC_LATCH_BIT = 3;
    localparam int SSC_SLEW_LSB = 4;
    localparam int SSC_DEGLITCH_LSB = 6;
    localparam int SSC_REVERSE_BIT = 4;
    localparam int SSC_SW_DIS_BIT = 0;

    // Slot codes
    localparam logic [3:0] SSC_SLOT_CODE_MAX = 4'hC;
    localparam logic [3:0] SSC_LAST_OUT_SLOT = 4'hB;
    localparam logic [3:0] SSC_LAST_MON_SLOT = 4'hC;

    // Timing: 20 MHz clock, all delays counted in 20 us ticks
    localparam int SSC_CLK_NS = 50;
    localparam int SSC_TICK_US = 20;
    localparam int SSC_TICK_CYCLES = (SSC_TICK_US * 1000) / SSC_CLK_NS;
    localparam int SSC_DLY_US [8] = '{20, 12500, 25000, 50000, 100000,
                                      200000, 400000, 1600000};
    localparam int SSC_FT_US [4] = '{25000, 50000, 100000, 200000};
    localparam int SSC_DEGLITCH_CNT [4] = '{2, 4, 8, 16};
    localparam int SSC_TIMER_W = 17;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } ssc_req_type;

endpackage : ssc_pkg

// ==== testbench/ssc_supply_model.sv ====
// Behavioural supplies: rail i follows enable output i with ramp delays
module ssc_supply_model #(
    parameter int RISE_CYC = 20,
    parameter int FALL_CYC = 6
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [11:0] en_out,
    input wire logic [11:0] fail_mask,
    output logic [11:0] rail_good
);
    timeunit 1ns;
    timeprecision 1ns;

    int cnt [12];
    logic [11:0] en_d;
    logic [11:0] up;

    // Discharge is quicker than charge, so the power-down check sees a drop
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            en_d <= '0;
            up <= '0;
            foreach (cnt[i]) cnt[i] <= 0;
        end else begin
            en_d <= en_out;
            foreach (cnt[i]) begin
                if (en_out[i] != en_d[i]) begin
                    cnt[i] <= 0;
                end else if (cnt[i] < 1000) begin
                    cnt[i] <= cnt[i] + 1;
                end
                if (en_d[i]) begin
                    up[i] <= (cnt[i] >= RISE_CYC);
                end else begin
                    up[i] <= up[i] && (cnt[i] < FALL_CYC);
                end
            end
        end
    end

    // A forced failure stands for a rail that sags while enabled
    assign rail_good = up & ~fail_mask;
endmodule : ssc_supply_model

// ==== testbench/tb.sv ====
// Self-checking bench for the slot sequencer configuration core
`define CHK(nm, e, g) \
    begin \
        tests_run++; \
        if ((g) !== (e)) begin \
            n_errors++; \
            $display("mismatch %s expected %0h seen %0h", nm, e, g); \
        end \
    end

module tb
    import ssc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0;
    logic rst = 1'b1;
    ssc_req_type req;
    logic [7:0] rdata;
    logic en_pin;
    logic conv_done;
    logic [11:0] good;
    logic [11:0] en_out;
    logic [11:0] fail_mask;
    logic rst_n_out;
    logic [3:0] pd;
    logic [1:0] slew;
    logic fault;
    logic pwr_on;
    int n_errors = 0;
    int tests_run = 0;
    logic [11:0] en_q [$];
    logic [7:0] rd_q [$];
    logic [11:0] en_last;
    logic [11:0] exp12;
    logic [7:0] exp8;
    logic rd_seen;

    always #25 clk = ~clk;

    ssc_sequencer u_dut (
        .clk(clk),
        .rst(rst),
        .reg_req(req),
        .reg_rdata(rdata),
        .en_pin(en_pin),
        .rail_monitor_good(good),
        .conv_done(conv_done),
        .en_out(en_out),
        .reset_out_n(rst_n_out),
        .tracking_sense_pulldown(pd),
        .slew_sel(slew),
        .fault_active(fault),
        .power_on(pwr_on)
    );

    ssc_supply_model u_sup (
        .clk(clk),
        .rst(rst),
        .en_out(en_out),
        .fail_mask(fail_mask),
        .rail_good(good)
    );

    // Each read answer and each enable change takes the oldest note
    always @(posedge clk) begin
        if (rst) begin
            en_last = 12'h000;
            rd_seen = 1'b0;
        end else begin
            if (rd_seen) begin
                exp8 = (rd_q.size() > 0) ? rd_q.pop_front() : 8'hXX;
                `CHK("reg_rdata", exp8, rdata)
            end
            rd_seen = req.rd;
            if (en_out !== en_last) begin
                exp12 = (en_q.size() > 0) ? en_q.pop_front() : 12'hXXX;
                `CHK("en_out", exp12, en_out)
                en_last = en_out;
            end
        end
    end

    task automatic results();
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        req.wr = 1'b1;
        req.addr = a;
        req.wdata = d;
        @(negedge clk);
        req.wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        req.rd = 1'b1;
        req.addr = a;
        rd_q.push_back(e);
        @(negedge clk);
        req.rd = 1'b0;
    endtask : rd

    task automatic conv(input int n);
        repeat (n) begin
            @(negedge clk);
            conv_done = 1'b1;
            @(negedge clk);
            conv_done = 1'b0;
        end
    endtask : conv

    // Bounded wait for power-on, or for all noted enable changes
    task automatic wait_for(input bit want_on);
        int i;
        for (i = 0; i < 20000; i++) begin
            @(negedge clk);
            if (want_on && pwr_on === 1'b1) break;
            if (!want_on && en_q.size() == 0) break;
        end
        `CHK("wait bound", 1, int'(i < 20000))
        if (i >= 20000) results();
        `CHK("pending enables", 0, en_q.size())
    endtask : wait_for

    initial begin
        logic [7:0] d;
        int c;
        req = '0;
        en_pin = 1'b0;
        conv_done = 1'b0;
        fail_mask = '0;
        void'($urandom(71046));
        tick(6);
        rst = 1'b0;
        for (int a = 8'h4D; a <= 8'h63; a++) rd(8'(a), SSC_REG_RST);
        for (int a = 8'h4E; a <= 8'h54; a++) begin
            d = 8'($urandom());
            wr(8'(a), d);
            rd(8'(a), (a == 8'h54) ? (d & 8'h1F) : d);
            if (a == 8'h4E) begin
                tick(1);
                `CHK("pulldown", d[7:4], pd)
            end
        end
        wr(8'h40, 8'h5A);
        rd(8'h40, 8'h00);
        wr(8'h5C, 8'hFF);
        rd(8'h5C, 8'h00);
        // Shortest delays and timeouts keep the run brief
        wr(SSC_TIMEOUT_PD_OFS, 8'hA0);
        wr(SSC_RETRY_OFS, 8'h00);
        for (int a = 8'h50; a <= 8'h53; a++) wr(8'(a), 8'h00);
        wr(SSC_DLY_REV_OFS, 8'h10);
        wr(SSC_MON_SLOT_OFS, 8'h21);
        wr(8'h57, 8'hEC);
        wr(SSC_OUT_SLOT_OFS, 8'h21);
        wr(8'h5F, 8'hDC);
        en_q = '{12'h001, 12'h003, 12'h007};
        en_pin = 1'b1;
        wait_for(1'b1);
        `CHK("reset_out_n on", 1'b1, rst_n_out)
        en_q = '{12'h003, 12'h001, 12'h000};
        wr(SSC_SW_ENABLE_OFS, 8'h01);
        tick(2);
        `CHK("reset_out_n down", 1'b0, rst_n_out)
        wait_for(1'b0);
        wr(SSC_DLY_REV_OFS, 8'h00);
        en_q = '{12'h001, 12'h003, 12'h007};
        wr(SSC_SW_ENABLE_OFS, 8'h00);
        wait_for(1'b1);
        en_q.push_back(12'h000);
        en_pin = 1'b0;
        tick(10);
        `CHK("all off at once", 0, en_q.size())
        `CHK("reset_out_n pin", 1'b0, rst_n_out)
        en_q = '{12'h001, 12'h003, 12'h007};
        en_pin = 1'b1;
        wait_for(1'b1);
        for (c = 0; c < 4; c++) begin
            wr(SSC_RETRY_OFS, 8'(c * 8'h50));
            tick(1);
            `CHK("slew_sel", 2'(c), slew)
            fail_mask = 12'h004;
            conv(SSC_DEGLITCH_CNT[c] - 1);
            tick(3);
            `CHK("fault early", 1'b0, fault)
            en_q.push_back(12'h000);
            conv(1);
            tick(3);
            `CHK("fault raised", 1'b1, fault)
            fail_mask = '0;
            en_q = {en_q, 12'h001, 12'h003, 12'h007};
            wait_for(1'b1);
        end
        wr(SSC_RETRY_OFS, 8'h08);
        fail_mask = 12'h004;
        en_q.push_back(12'h000);
        conv(2);
        fail_mask = '0;
        tick(1000);
        `CHK("latched fault", 1'b1, fault)
        `CHK("latched power", 1'b0, pwr_on)
        wr(SSC_SW_ENABLE_OFS, 8'h01);
        tick(4);
        `CHK("latch released", 1'b0, fault)
        results();
    end
endmodule : tb
